// *** design/ufd_core.sv ***
// full-speed usb device endpoint logic behind an APB register port
// assumes the serial interface engine runs on core_clk and hands over
// decoded tokens, end-of-packet and host ACK as one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
`include "ufd_map.svh"

// Operation
// - seven-bit address, reset zero, filters tokens
// - read-only done flags per endpoint
// - enable bit beside each done flag
// - transceiver active only while enable set
// - pseudo frame generator runs while enabled
// - wakeup bit drives resume, then self-clears
// - four-bit index selects endpoint register bank
// - receive stall: STALL, NAK when setup pending
// - transmit stall: STALL, NAK when setup pending
// - only control endpoint zero takes SETUP
// - input disabled: discard OUT, NAK; SETUP passes
// - receive disabled ignores OUT and SETUP
// - output disabled answers IN with NAK
// - transmit disabled ignores IN tokens
// - data write pushes byte, advances pointer
// - clear bit flushes FIFO, resets flags
// - empty flag tracks FIFO live
// - count write sets full; ACK clears
// - read of empty FIFO sets underrun
// - write to full FIFO sets overrun
// - sequence bit toggles on ACK, SETUP
module ufd_core #(
    parameter int DEPTH      = 64,                                  // bytes per transmit FIFO
    parameter int RESUME_CYC = `UFD_RESUME_US * `UFD_CLK_MHZ,       // resume signalling length
    parameter int FRAME_CYC  = `UFD_FRAME_US * `UFD_CLK_MHZ         // pseudo frame period
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // APB register port
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [7:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // tokens and packet events from the serial interface engine
    input  wire logic                 tokValid,
    input  wire ufd_pkg::ufd_tok_t    tokKind,
    input  wire logic [6:0]           tokAddr,
    input  wire logic [3:0]           tokEp,
    input  wire logic                 rxDone,
    input  wire logic                 hostAck,
    input  wire logic                 txReady,
    // answers and IN data to the engine
    output logic                      hsValid,
    output ufd_pkg::ufd_hs_t          hsCode,
    output logic                      txValid,
    output logic      [7:0]           txData,
    output logic                      txLast,
    output logic                      txPidSeq,
    // transceiver and pins
    output logic                      usbEnable,
    output logic                      plusPullup,
    output logic                      minusPullup,
    output logic                      resumeDrive,
    output logic                      frameMarker,
    output logic                      irq
);
    import ufd_pkg::*;

    localparam int NSL = 8;                       // banked endpoints 0-6 and 9
    localparam int PW  = $clog2(DEPTH) + 1;       // pointer with wrap bit

    // map an endpoint number to a bank slot, 8 means no bank
    function automatic logic [3:0] epSlot(input logic [3:0] ep);
        if (ep <= 4'h6) return ep;
        if (ep == 4'h9) return 4'h7;
        return 4'h8;
    endfunction : epSlot

    // done flag position for a slot; ep0 splits receive and transmit
    function automatic logic [10:0] doneMask(input logic [2:0] sl, input logic isTx);
        if (sl == 3'h0) return isTx ? 11'h001 : 11'h002;
        if (sl == 3'h7) return 11'h400;
        return 11'(11'h002 << sl);
    endfunction : doneMask

    // reset synchroniser, first stage feeds only the second
    logic [1:0] rstSync_ff;
    logic       rstN;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b) rstSync_ff <= 2'h0;
        else        rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
    assign rstN = rstSync_ff[1];

    // register and link state
    logic [6:0]    fa_ff, nxt_fa;                     // device_address_field
    logic [10:0]   done_ff, nxt_done;
    logic [10:0]   doneIe_ff, nxt_doneIe;
    logic [5:0]    xcvr_ff, nxt_xcvr;                 // transceiver control bits
    logic [3:0]    epSel_ff, nxt_epSel;
    logic [7:0]    epCon_ff [NSL], nxt_epCon [NSL];
    logic [6:0]    txCnt_ff [NSL], nxt_txCnt [NSL];
    logic [PW-1:0] wrPtr_ff [NSL], nxt_wrPtr [NSL];
    logic [PW-1:0] rdPtr_ff [NSL], nxt_rdPtr [NSL];
    logic [NSL-1:0] txFull_ff, nxt_txFull, txUrf_ff, nxt_txUrf, txOvf_ff, nxt_txOvf;
    logic [NSL-1:0] txSeq_ff, nxt_txSeq;
    logic          setupPend_ff, nxt_setupPend;       // setup_pending_flag
    ufd_st_t       st_ff, nxt_st;
    logic [2:0]    curSl_ff, nxt_curSl;               // slot of the live transaction
    logic [6:0]    sent_ff, nxt_sent;
    logic          setup_pending_flag_ff, nxt_setup_pending_flag;
    ufd_hs_t       rxAns_ff, nxt_rxAns;
    logic [31:0]   wake_ff, nxt_wake;
    logic [31:0]   frame_ff, nxt_frame;
    logic [31:0]   prdata_ff, nxt_prdata;
    logic          pready_ff, pslverr_ff, nxt_pslverr;
    logic          hsValid_ff, nxt_hsValid, txValid_ff, nxt_txValid;
    logic          txLast_ff, nxt_txLast, frameMk_ff, nxt_frameMk, irq_ff, nxt_irq;
    ufd_hs_t       hsCode_ff, nxt_hsCode;
    logic [7:0]    txData_ff, nxt_txData;
    logic [7:0]    txMem [NSL][DEPTH];                // transmit FIFO storage
    logic          memWe;
    logic [2:0]    memSl;
    logic [PW-2:0] memIdx;

    // decoded access and selected bank
    logic       apbAcc, apbWr;
    logic [3:0] selSl, tokSl;
    assign apbAcc = PSEL && PENABLE && !pready_ff;    // one wait state per access
    assign apbWr  = apbAcc && PWRITE;
    assign selSl  = epSlot(epSel_ff);
    assign tokSl  = epSlot(tokEp);

    // next-state logic of registers, FIFOs and the transaction sequencer
    always_comb
    begin
        logic [2:0] s;
        logic [2:0] t;
        logic [7:0] ec;
        logic       hit;
        s = selSl[2:0];
        t = tokSl[2:0];
        ec = epCon_ff[t];
        hit = 1'b0;
        nxt_fa = fa_ff; nxt_done = done_ff; nxt_doneIe = doneIe_ff; nxt_xcvr = xcvr_ff;
        nxt_epSel = epSel_ff; nxt_epCon = epCon_ff; nxt_txCnt = txCnt_ff;
        nxt_wrPtr = wrPtr_ff; nxt_rdPtr = rdPtr_ff; nxt_txFull = txFull_ff;
        nxt_txUrf = txUrf_ff; nxt_txOvf = txOvf_ff; nxt_txSeq = txSeq_ff;
        nxt_setupPend = setupPend_ff; nxt_st = st_ff; nxt_curSl = curSl_ff;
        nxt_sent = sent_ff; nxt_setup_pending_flag = setup_pending_flag_ff; nxt_rxAns = rxAns_ff;
        nxt_prdata = prdata_ff; nxt_pslverr = 1'b0;
        nxt_hsValid = 1'b0; nxt_hsCode = UFD_HS_NONE; nxt_txValid = txValid_ff;
        nxt_txLast = txLast_ff; nxt_txData = txData_ff;
        memWe = 1'b0; memSl = s; memIdx = wrPtr_ff[s][PW-2:0];
        // firmware side: register writes and their side effects
        if (apbWr)
        begin
            case (PADDR)
                `UFD_OFS_FADDR:    nxt_fa = PWDATA[6:0];
                `UFD_OFS_DONE_IE:  nxt_doneIe = PWDATA[10:0] & 11'h4FF;
                `UFD_OFS_DONE_CLR: nxt_done = done_ff & ~PWDATA[10:0];
                `UFD_OFS_XCVR:     nxt_xcvr = {PWDATA[5:3], 1'b0, PWDATA[1],
                                               PWDATA[0] | xcvr_ff[0]};
                `UFD_OFS_SETUP:    if (!PWDATA[0]) nxt_setupPend = 1'b0;
                `UFD_OFS_EPSEL:    nxt_epSel = PWDATA[3:0];
                default:           nxt_pslverr = 1'b0;
            endcase
            if (!selSl[3])
            begin
                case (PADDR)
                    `UFD_OFS_EPCON:  nxt_epCon[s] = {PWDATA[7:6], PWDATA[5] & (s == 3'h0),
                                                     1'b0, PWDATA[3:0]};
                    `UFD_OFS_TXDAT:
                    begin
                        if (txFull_ff[s] || (wrPtr_ff[s] - rdPtr_ff[s]) == PW'(DEPTH))
                            nxt_txOvf[s] = 1'b1;
                        else
                        begin
                            memWe = 1'b1;
                            nxt_wrPtr[s] = wrPtr_ff[s] + 1'b1;
                        end
                    end
                    `UFD_OFS_TXCON:
                        if (PWDATA[`UFD_BIT_TXCLR])
                        begin
                            // flush happens in one cycle so the bit never reads back set
                            nxt_wrPtr[s] = '0; nxt_rdPtr[s] = '0;
                            nxt_txFull[s] = 1'b0; nxt_txUrf[s] = 1'b0; nxt_txOvf[s] = 1'b0;
                        end
                    `UFD_OFS_TXFLG:
                    begin
                        if (!PWDATA[`UFD_BIT_TXURF]) nxt_txUrf[s] = 1'b0;
                        if (!PWDATA[`UFD_BIT_TXOVF]) nxt_txOvf[s] = 1'b0;
                    end
                    `UFD_OFS_TXCNT:
                    begin
                        nxt_txCnt[s] = PWDATA[6:0];
                        nxt_txFull[s] = 1'b1;
                    end
                    `UFD_OFS_TXSTAT: if (!PWDATA[`UFD_BIT_TXSEQ]) nxt_txSeq[s] = 1'b0;
                    default:         nxt_pslverr = 1'b0;
                endcase
            end
        end
        // remote wakeup completes after the resume interval
        if (xcvr_ff[0] && wake_ff == 32'(RESUME_CYC - 1)) nxt_xcvr[0] = 1'b0;
        // link side: token decode, answered only when addressed and enabled
        hit = tokValid && xcvr_ff[`UFD_BIT_USBEN] && tokAddr == fa_ff && !tokSl[3];
        case (st_ff)
            UFD_ST_IDLE:
                if (hit)
                begin
                    nxt_curSl = t;
                    if (tokKind == UFD_TOK_IN && ec[`UFD_BIT_TXEPEN])
                    begin
                        nxt_hsValid = 1'b1;
                        if (ec[`UFD_BIT_TXSTL])
                            nxt_hsCode = setupPend_ff ? UFD_HS_NAK : UFD_HS_STALL;
                        else if (!ec[`UFD_BIT_TXOE] || !txFull_ff[t])
                            nxt_hsCode = UFD_HS_NAK;
                        else if (txCnt_ff[t] == 7'h00)
                        begin
                            nxt_hsCode = UFD_HS_ZLP;
                            nxt_st = UFD_ST_WACK;
                        end
                        else
                        begin
                            nxt_hsValid = 1'b0;
                            nxt_st = UFD_ST_SEND;
                            nxt_sent = 7'h00;
                            nxt_txValid = 1'b1;
                            nxt_txLast = txCnt_ff[t] == 7'h01;
                            nxt_txData = txMem[t][rdPtr_ff[t][PW-2:0]];
                        end
                    end
                    else if (tokKind == UFD_TOK_OUT && ec[`UFD_BIT_RXEPEN])
                    begin
                        nxt_st = UFD_ST_RXW;
                        nxt_setup_pending_flag = 1'b0;
                        if (ec[`UFD_BIT_RXSTL])
                            nxt_rxAns = setupPend_ff ? UFD_HS_NAK : UFD_HS_STALL;
                        else if (!ec[`UFD_BIT_RXIE])
                            nxt_rxAns = UFD_HS_NAK;
                        else
                            nxt_rxAns = UFD_HS_ACK;
                    end
                    else if (tokKind == UFD_TOK_SETUP && ec[`UFD_BIT_RXEPEN]
                             && ec[`UFD_BIT_CTLEP])
                    begin
                        // setup overrides input enable and stall
                        nxt_st = UFD_ST_RXW;
                        nxt_setup_pending_flag = 1'b1;
                        nxt_rxAns = UFD_HS_ACK;
                        nxt_txSeq[t] = ~txSeq_ff[t];
                    end
                end
            UFD_ST_SEND:
                if (txReady)
                begin
                    if (rdPtr_ff[curSl_ff] == wrPtr_ff[curSl_ff])
                        nxt_txUrf[curSl_ff] = 1'b1;
                    else
                        nxt_rdPtr[curSl_ff] = rdPtr_ff[curSl_ff] + 1'b1;
                    nxt_sent = sent_ff + 7'h01;
                    nxt_txData = txMem[curSl_ff][nxt_rdPtr[curSl_ff][PW-2:0]];
                    nxt_txLast = (sent_ff + 7'h02) == txCnt_ff[curSl_ff];
                    if (txLast_ff)
                    begin
                        nxt_txValid = 1'b0;
                        nxt_txLast = 1'b0;
                        nxt_st = UFD_ST_WACK;
                    end
                end
            UFD_ST_WACK:
                if (hostAck)
                begin
                    nxt_txFull[curSl_ff] = 1'b0;
                    nxt_txSeq[curSl_ff] = ~txSeq_ff[curSl_ff];
                    nxt_done = nxt_done | doneMask(curSl_ff, 1'b1);
                    nxt_st = UFD_ST_IDLE;
                end
                else if (tokValid)
                    nxt_st = UFD_ST_IDLE;      // no handshake came, transfer stays pending
            UFD_ST_RXW:
                if (rxDone)
                begin
                    // receive data is not stored here; only the handshake is decided
                    nxt_hsValid = 1'b1;
                    nxt_hsCode = rxAns_ff;
                    if (rxAns_ff == UFD_HS_ACK)
                        nxt_done = nxt_done | doneMask(curSl_ff, 1'b0);
                    if (setup_pending_flag_ff) nxt_setupPend = 1'b1;
                    nxt_st = UFD_ST_IDLE;
                end
                else if (tokValid)
                    nxt_st = UFD_ST_IDLE;
            default: nxt_st = UFD_ST_IDLE;
        endcase
        // register read data, captured in the wait cycle
        if (apbAcc && !PWRITE)
        begin
            case (PADDR)
                `UFD_OFS_FADDR:   nxt_prdata = {25'h0, fa_ff};
                `UFD_OFS_DONE:    nxt_prdata = {21'h0, done_ff};
                `UFD_OFS_DONE_IE: nxt_prdata = {21'h0, doneIe_ff};
                `UFD_OFS_XCVR:    nxt_prdata = {26'h0, xcvr_ff};
                `UFD_OFS_SETUP:   nxt_prdata = {31'h0, setupPend_ff};
                `UFD_OFS_EPSEL:   nxt_prdata = {28'h0, epSel_ff};
                `UFD_OFS_EPCON:   nxt_prdata = selSl[3] ? 32'h0 : {24'h0, epCon_ff[s]};
                `UFD_OFS_TXFLG:   nxt_prdata = selSl[3] ? 32'h0 :
                                  {28'h0, wrPtr_ff[s] == rdPtr_ff[s],
                                   txFull_ff[s], txUrf_ff[s], txOvf_ff[s]};
                `UFD_OFS_TXSTAT:  nxt_prdata = selSl[3] ? 32'h0 : {24'h0, txSeq_ff[s], 7'h0};
                default:          nxt_prdata = 32'h0;                             // write-only
            endcase
        end
        if (apbAcc)
            nxt_pslverr = !(PADDR inside {`UFD_OFS_FADDR, `UFD_OFS_DONE, `UFD_OFS_DONE_IE,
                            `UFD_OFS_XCVR, `UFD_OFS_SETUP, `UFD_OFS_EPSEL, `UFD_OFS_EPCON,
                            `UFD_OFS_TXDAT, `UFD_OFS_TXCON, `UFD_OFS_TXFLG, `UFD_OFS_TXCNT,
                            `UFD_OFS_TXSTAT, `UFD_OFS_DONE_CLR});
        // wake and frame counters
        nxt_wake = (xcvr_ff[0] && wake_ff != 32'(RESUME_CYC - 1)) ? wake_ff + 32'h1 : 32'h0;
        nxt_frameMk = 1'b0;
        nxt_frame = 32'h0;
        if (xcvr_ff[`UFD_BIT_PSEUDO_FRAME_MARKER])
        begin
            nxt_frame = (frame_ff == 32'(FRAME_CYC - 1)) ? 32'h0 : frame_ff + 32'h1;
            nxt_frameMk = frame_ff == 32'(FRAME_CYC - 1);
        end
        nxt_irq = |(nxt_done & nxt_doneIe);
    end

    // transmit FIFO storage, written only by the data register
    always_ff @(posedge core_clk)
    begin
        if (memWe) txMem[memSl][memIdx] <= PWDATA[7:0];
    end

    // register stage of all control state
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            fa_ff <= 7'h00; done_ff <= 11'h000; doneIe_ff <= 11'h000; xcvr_ff <= 6'h00;
            epSel_ff <= 4'h0; setupPend_ff <= 1'b0; st_ff <= UFD_ST_IDLE;
            curSl_ff <= 3'h0; sent_ff <= 7'h00; setup_pending_flag_ff <= 1'b0; rxAns_ff <= UFD_HS_NONE;
            wake_ff <= 32'h0; frame_ff <= 32'h0; prdata_ff <= 32'h0;
            pready_ff <= 1'b0; pslverr_ff <= 1'b0; hsValid_ff <= 1'b0;
            hsCode_ff <= UFD_HS_NONE; txValid_ff <= 1'b0; txLast_ff <= 1'b0;
            txData_ff <= 8'h00; frameMk_ff <= 1'b0; irq_ff <= 1'b0;
            txFull_ff <= '0; txUrf_ff <= '0; txOvf_ff <= '0; txSeq_ff <= '0;
            for (int i = 0; i < NSL; i++)
            begin
                // endpoint zero starts as an enabled control endpoint
                epCon_ff[i] <= (i == 0) ? `UFD_EPCON_RST_EP0 : `UFD_EPCON_RST;
                txCnt_ff[i] <= 7'h00;
                wrPtr_ff[i] <= '0;
                rdPtr_ff[i] <= '0;
            end
        end
        else
        begin
            fa_ff <= nxt_fa; done_ff <= nxt_done; doneIe_ff <= nxt_doneIe;
            xcvr_ff <= nxt_xcvr; epSel_ff <= nxt_epSel; setupPend_ff <= nxt_setupPend;
            st_ff <= nxt_st; curSl_ff <= nxt_curSl; sent_ff <= nxt_sent;
            setup_pending_flag_ff <= nxt_setup_pending_flag; rxAns_ff <= nxt_rxAns;
            wake_ff <= nxt_wake; frame_ff <= nxt_frame; prdata_ff <= nxt_prdata;
            pready_ff <= apbAcc; pslverr_ff <= nxt_pslverr;
            hsValid_ff <= nxt_hsValid; hsCode_ff <= nxt_hsCode;
            txValid_ff <= nxt_txValid; txLast_ff <= nxt_txLast; txData_ff <= nxt_txData;
            frameMk_ff <= nxt_frameMk; irq_ff <= nxt_irq;
            txFull_ff <= nxt_txFull; txUrf_ff <= nxt_txUrf; txOvf_ff <= nxt_txOvf;
            txSeq_ff <= nxt_txSeq;
            epCon_ff <= nxt_epCon; txCnt_ff <= nxt_txCnt;
            wrPtr_ff <= nxt_wrPtr; rdPtr_ff <= nxt_rdPtr;
        end
    end

    // outputs straight from flip-flops, except txPidSeq, which a mux selects by curSl_ff
    assign PRDATA      = prdata_ff;
    assign PREADY      = pready_ff;
    assign PSLVERR     = pslverr_ff;
    assign hsValid     = hsValid_ff;
    assign hsCode      = hsCode_ff;
    assign txValid     = txValid_ff;
    assign txData      = txData_ff;
    assign txLast      = txLast_ff;
    assign txPidSeq    = txSeq_ff[curSl_ff];
    assign usbEnable   = xcvr_ff[`UFD_BIT_USBEN];
    assign plusPullup  = xcvr_ff[`UFD_BIT_PLUS];
    assign minusPullup = xcvr_ff[`UFD_BIT_MINUS];
    assign resumeDrive = xcvr_ff[`UFD_BIT_WAKE];
    assign frameMarker = frameMk_ff;
    assign irq         = irq_ff;
endmodule : ufd_core
`default_nettype wire

// *** shared/ufd_map.svh ***
// register offsets, field positions, reset values and timing counts of
// the full-speed device endpoint block; assumes a byte-addressed APB port
`ifndef UFD_MAP_SVH
`define UFD_MAP_SVH
`define UFD_OFS_FADDR     8'h00
`define UFD_OFS_DONE      8'h04
`define UFD_OFS_DONE_IE   8'h08
`define UFD_OFS_XCVR      8'h0C
`define UFD_OFS_SETUP     8'h10
`define UFD_OFS_EPSEL     8'h14
`define UFD_OFS_EPCON     8'h18
`define UFD_OFS_TXDAT     8'h20
`define UFD_OFS_TXCON     8'h24
`define UFD_OFS_TXFLG     8'h28
`define UFD_OFS_TXCNT     8'h2C
`define UFD_OFS_TXSTAT    8'h30
`define UFD_OFS_DONE_CLR  8'h40
`define UFD_BIT_USBEN     5
`define UFD_BIT_MINUS     4
`define UFD_BIT_PSEUDO_FRAME_MARKER      3
`define UFD_BIT_PLUS      1
`define UFD_BIT_WAKE      0
`define UFD_BIT_RXSTL     7
`define UFD_BIT_TXSTL     6
`define UFD_BIT_CTLEP     5
`define UFD_BIT_RXIE      3
`define UFD_BIT_RXEPEN    2
`define UFD_BIT_TXOE      1
`define UFD_BIT_TXEPEN    0
`define UFD_BIT_TXCLR     7
`define UFD_BIT_TXEMP     3
`define UFD_BIT_TXFULL    2
`define UFD_BIT_TXURF     1
`define UFD_BIT_TXOVF     0
`define UFD_BIT_TXSEQ     7
`define UFD_EPCON_RST_EP0 8'h25
`define UFD_EPCON_RST     8'h00
`define UFD_CLK_MHZ       100
`define UFD_RESUME_US     10000
`define UFD_FRAME_US      1000
`endif

// *** shared/ufd_pkg.sv ***
// types shared by the endpoint block and its bench
package ufd_pkg;
    // token kinds handed over by the serial interface engine
    typedef enum logic [1:0] {UFD_TOK_OUT = 2'h0, UFD_TOK_IN = 2'h1,
                              UFD_TOK_SETUP = 2'h2, UFD_TOK_NONE = 2'h3} ufd_tok_t;
    // answers returned to the engine
    typedef enum logic [2:0] {UFD_HS_NONE = 3'h0, UFD_HS_ACK = 3'h1, UFD_HS_NAK = 3'h2,
                              UFD_HS_STALL = 3'h3, UFD_HS_ZLP = 3'h4} ufd_hs_t;
    // transaction sequencer, gray along idle-send-ack
    typedef enum logic [1:0] {UFD_ST_IDLE = 2'b00, UFD_ST_SEND = 2'b01,
                              UFD_ST_WACK = 2'b11, UFD_ST_RXW = 2'b10} ufd_st_t;
endpackage : ufd_pkg

// *** verif/ufd_core_properties.sv ***
// port-level checks on the endpoint block, bound into ufd_core
// assumes the bench shrinks frame and resume counts to 16 and 20
`timescale 1ns/1ns
`default_nettype none
module ufd_core_properties (
    input wire logic core_clk, rst_b, PSEL, PENABLE, PREADY, PSLVERR, tokValid,
    input wire logic hsValid, txValid, txReady, usbEnable, frameMarker, resumeDrive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // no second frame pulse in the eight cycles after one
    sequence s_quiet; (!frameMarker) [*8]; endsequence
    // resume lines held high for the first eight cycles of the signalling
    sequence s_resume; resumeDrive [*8]; endsequence
    AST_APB_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    AST_APB_ONE: assert property (PREADY |=> !PREADY) else $error("ready too long");
    AST_ERR_READY: assert property (PSLVERR |-> PREADY) else $error("lone error");
    AST_OFF_SILENT: assert property (tokValid && !usbEnable |=> !hsValid && !txValid)
        else $error("answer while off");
    AST_HS_PULSE: assert property (hsValid |=> !hsValid) else $error("long answer");
    AST_FRAME_GAP: assert property (frameMarker |=> s_quiet) else $error("frame gap");
    AST_RESUME_LEN: assert property ($rose(resumeDrive) |-> s_resume)
        else $error("short resume");
    AST_TX_HOLD: assert property (txValid && !txReady |=> txValid) else $error("byte lost");
    AST_CTRL_STABLE: assert property (!PSEL && !$past(PSEL) |=> $stable(usbEnable))
        else $error("enable moved");
endmodule : ufd_core_properties
bind ufd_core ufd_core_properties u_props (.*);
`default_nettype wire

// *** verif/ufd_host_model.sv ***
// host side of the link: sends tokens, takes IN bytes, acknowledges
// the bench calls tok and sets slow through this instance
`timescale 1ns/1ns
`default_nettype none
module ufd_host_model (
    input  wire logic         core_clk, txValid, txLast,
    output ufd_pkg::ufd_tok_t tokKind,
    output logic              tokValid, rxDone, hostAck, txReady,
    output logic [6:0]        tokAddr,
    output logic [3:0]        tokEp
);
    import ufd_pkg::*;
    logic slow = 1'b0;      // stall the stream by toggling ready
    logic lastTaken = 1'b0; // final byte crossed at this edge
    initial
    begin
        {tokValid, rxDone, hostAck, txReady} = 4'h0;
        tokKind = UFD_TOK_NONE;
        {tokAddr, tokEp} = 11'h555;
    end
    always @(posedge core_clk) lastTaken <= txValid && txReady && txLast;
    always @(posedge core_clk) rxDone <= tokValid && tokKind != UFD_TOK_IN; // packet ends
    // ack trails the final byte so the device is already waiting for it
    always @(negedge core_clk)
    begin
        txReady <= slow ? !txReady : 1'b1;
        hostAck <= lastTaken;
    end
    // token lasts one cycle; address and endpoint lines then show the inverse and kind shows none, not stale values
    task automatic tok(input ufd_tok_t k, input logic [6:0] a);
        @(negedge core_clk);
        {tokValid, tokAddr, tokEp} = {1'b1, a, 4'h0};
        tokKind = k;
        @(negedge core_clk);
        {tokValid, tokAddr, tokEp} = {1'b0, ~a, 4'hF};
        tokKind = UFD_TOK_NONE;
    endtask : tok
endmodule : ufd_host_model
`default_nettype wire

// *** verif/usb_fullspeed_device_endpoints_tb_top.sv ***
// bench for the endpoint block: APB tasks on one side, host model on the link
// assumes short resume and frame counts; inputs change on falling edges, rxDone on rising ones
`timescale 1ns/1ns
`default_nettype none
module usb_fullspeed_device_endpoints_tb_top;
    import ufd_pkg::*;
    logic        core_clk = 1'b0, rst_b = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00, txData;
    logic [31:0] PWDATA = 32'h0, PRDATA, r;
    logic        PREADY, PSLVERR, slvErr, tokValid, rxDone, hostAck, txReady, hsValid, txValid;
    logic        txLast, txPidSeq, usbEnable, plusPullup, minusPullup, resumeDrive, frameMarker;
    logic        irq;
    logic [6:0]  tokAddr;
    logic [3:0]  tokEp;
    ufd_tok_t    tokKind;
    ufd_hs_t     hsCode, hs;
    int          fail_count = 0, checked = 0, cyc = 0, fm = 0;
    logic [7:0]  q[$]; // bytes the host took
    always #5 core_clk = ~core_clk;
    ufd_core #(.RESUME_CYC(20), .FRAME_CYC(16)) dut_u (.*);
    ufd_host_model hm (.*);
    // cycle ceiling, frame pulse count and IN byte capture
    always @(posedge core_clk)
    begin
        cyc++;
        fm += (frameMarker === 1'b1);
        if (txValid === 1'b1 && txReady === 1'b1) q.push_back(txData);
        if (cyc == 3000)
        begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out;
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, want);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    // one APB transfer; request held until ready is sampled high
    task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        {PSEL, PWRITE, PADDR, PWDATA} = {1'b1, w, a, d};
        @(negedge core_clk);
        PENABLE = 1'b1;
        do @(posedge core_clk); while (PREADY !== 1'b1);
        {r, slvErr} = {PRDATA, PSLVERR};
        @(negedge core_clk);
        {PSEL, PENABLE} = 2'b00;
    endtask : ap
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ap(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd
    // bounded wait for a handshake answer
    task automatic wh;
        hs = UFD_HS_NONE;
        repeat (6) @(posedge core_clk) if (hsValid === 1'b1) hs = hsCode;
    endtask : wh
    task automatic t_regs;
        rd(8'h00, 32'h0);
        rd(8'h18, 32'h25);
        rd(8'h28, 32'h08);
        ap(1'b0, 8'h1C, 32'h0);
        chk(slvErr, 1'b1);
        ap(1'b1, 8'h00, 32'h7F);
        rd(8'h00, 32'h7F);
        ap(1'b1, 8'h14, 32'h7);
        rd(8'h18, 32'h0);
        ap(1'b1, 8'h14, 32'h0);
        hm.tok(UFD_TOK_IN, 7'h7F);
        wh();
        chk(hs, UFD_HS_NONE);
    endtask : t_regs
    task automatic t_in;
        ap(1'b1, 8'h0C, 32'h20);
        ap(1'b1, 8'h18, 32'h27);
        ap(1'b1, 8'h20, 32'hA5);
        ap(1'b1, 8'h20, 32'h3C);
        ap(1'b1, 8'h2C, 32'h2);
        rd(8'h28, 32'h04);
        hm.slow = 1'b1;
        hm.tok(UFD_TOK_IN, 7'h7F);
        repeat (12) @(posedge core_clk);
        chk({q.size(), q[0], q[1]}, {32'h2, 16'hA53C});
        rd(8'h28, 32'h08);
        rd(8'h30, 32'h80);
        chk({txPidSeq, irq}, 2'b10);
        rd(8'h04, 32'h1);
        ap(1'b1, 8'h08, 32'h1);
        chk(irq, 1'b1);
        ap(1'b1, 8'h40, 32'h1);
        chk(irq, 1'b0);
        hm.tok(UFD_TOK_IN, 7'h12);
        wh();
        chk(hs, UFD_HS_NONE);
    endtask : t_in
    task automatic t_hs;
        logic [7:0] ev[6] = '{8'h67, 8'h25, 8'h24, 8'hA5, 8'hA5, 8'hA5};
        ufd_hs_t    eh[6] = '{UFD_HS_STALL, UFD_HS_NAK, UFD_HS_NONE, UFD_HS_STALL, UFD_HS_ACK,
                              UFD_HS_NAK};
        for (int i = 0; i < 6; i++)
        begin
            ap(1'b1, 8'h18, {24'h0, ev[i]});
            hm.tok(i < 3 ? UFD_TOK_IN : i == 4 ? UFD_TOK_SETUP : UFD_TOK_OUT, 7'h7F);
            wh();
            chk(hs, eh[i]);
        end
    endtask : t_hs
    task automatic t_pins;
        ap(1'b1, 8'h20, 32'h5A);
        ap(1'b1, 8'h2C, 32'h1);
        ap(1'b1, 8'h20, 32'h11);
        rd(8'h28, 32'h05);
        ap(1'b1, 8'h24, 32'h80);
        rd(8'h28, 32'h08);
        ap(1'b1, 8'h0C, 32'h39);
        rd(8'h0C, 32'h39);
        chk({usbEnable, minusPullup, plusPullup, resumeDrive}, 4'hD);
        repeat (30) @(posedge core_clk);
        rd(8'h0C, 32'h38);
        chk(fm > 0, 1'b1);
        ap(1'b1, 8'h0C, 32'h20);
        fm = 0;
        repeat (40) @(posedge core_clk);
        chk(fm, 32'h0);
    endtask : t_pins
    initial
    begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        t_regs();
        t_in();
        t_hs();
        t_pins();
        close_out();
    end
endmodule : usb_fullspeed_device_endpoints_tb_top
`default_nettype wire
